/* verilog/plc_link_top.sv */
// Purpose: link capabilities and link control registers of a root port
// Assumes: AXI4-Lite access; LTSSM and transmitter logic share mclk
// Notes: mclk 40 MHz; ce low freezes every flip-flop
//
// How it works
// - L0s exit latency, write-once, resets 100b
// - ASPM support field write-once, resets 11b
// - maximum link width is read-only
// - maximum link speed read-only, 2.5 Gb/s
// - link control comes out of reset zero
// - extended synch: 4096 FTS then one SKP
// - extended synch: 1024 TS1 before Recovery
// - common clock bit is plain read/write
// - writing retrain one sends LTSSM to Recovery
// - retrain bit always reads zero
// - link disable bit holds the link down
// - link disable reads back last write at once
// - RCB bit write-once, zero 64B, one 128B
// - ASPM control enables L0s and L1 entry
// - training flag set by retrain, cleared on exit
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module plc_link_top #(
   parameter logic [5:0] MAX_WIDTH = plc_pkg::WIDTH_DEF,
   parameter logic [3:0] MAX_SPEED = plc_pkg::SPEED_DEF,
   parameter int unsigned N_EXT_FTS = plc_pkg::EXT_FTS,
   parameter int unsigned N_EXT_TS1 = plc_pkg::EXT_TS1,
   parameter int unsigned N_NORM_FTS = plc_pkg::NORM_FTS,
   parameter int unsigned N_NORM_TS1 = plc_pkg::NORM_TS1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [plc_pkg::PLC_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [plc_pkg::PLC_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ltssm_cfg_rec,
   output logic retrain_req,
   output logic link_disable,
   output logic [1:0] aspm_ctl,
   output logic common_clk,
   output logic rcb_128,
   output logic link_training,
   input wire logic l0s_exit_start,
   input wire logic l1_exit_start,
   input wire logic tx_os_ready,
   output logic tx_os_valid,
   output plc_pkg::plc_os_e tx_os_kind,
   output logic os_seq_done
);
   import plc_pkg::*;

   // ==========================================
   // state
   typedef struct packed {
      logic [2:0] lat;
      logic [1:0] aspm_sup;
      logic cap_locked;
      logic xsync;
      logic cclk;
      logic ldis;
      logic rcb;
      logic rcb_locked;
      logic [1:0] aspm;
      logic retrain;
      logic train_pend;
      logic cfg_rec_q;
      logic training;
      logic seen_cap;
      logic seen_ctl;
      logic ah_l1;
      logic ah_ext;
      logic [CNT_W-1:0] ah_cnt;
   } plc_top_s;
   localparam plc_top_s TOP_RST = '{lat: LAT_RST, aspm_sup: ASPMS_RST, aspm: ASPMC_RST,
                                    default: '0};
   plc_top_s s, next_s;
   logic wr_cap, wr_ctl, ctl_lane, retrain_wr, os_take;

   plc_reg_if rif ();

   // ==========================================
   // bus front end
   plc_axil u_axil (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .rif(rif.bus)
   );

   // ==========================================
   // ordered-set sequencer
   plc_os_seq #(
      .N_EXT_FTS(N_EXT_FTS),
      .N_EXT_TS1(N_EXT_TS1),
      .N_NORM_FTS(N_NORM_FTS),
      .N_NORM_TS1(N_NORM_TS1)
   ) u_seq (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .ext_synch(s.xsync),
      .l0s_exit(l0s_exit_start),
      .l1_exit(l1_exit_start),
      .os_ready(tx_os_ready),
      .os_valid(tx_os_valid),
      .os_kind(tx_os_kind),
      .os_done(os_seq_done)
   );

   // ==========================================
   // register writes
   assign wr_cap = rif.wr_en && plc_hit(rif.wr_addr, PLC_LCAP_OFF);
   assign wr_ctl = rif.wr_en && plc_hit(rif.wr_addr, PLC_LCTL_OFF);
   assign ctl_lane = wr_ctl && rif.wstrb[LANE_CTL];
   assign retrain_wr = ctl_lane && rif.wdata[CTL_RETRAIN];
   assign os_take = tx_os_valid && tx_os_ready;
   assign rif.wr_err = !(plc_hit(rif.wr_addr, PLC_LCAP_OFF) ||
                         plc_hit(rif.wr_addr, PLC_LCTL_OFF));

   always_comb begin
      next_s = s;
      next_s.retrain = 1'b0;
      next_s.cfg_rec_q = ltssm_cfg_rec;
      // a write that misses the field's byte lane does not use up the lock
      if (wr_cap && rif.wstrb[LANE_WO] && !s.cap_locked) begin
         next_s.lat = rif.wdata[CAP_LAT_LO +: 3];
         next_s.aspm_sup = rif.wdata[CAP_ASPM_LO +: 2];
         next_s.cap_locked = 1'b1;
      end
      if (ctl_lane) begin
         next_s.xsync = rif.wdata[CTL_XSYNC];
         next_s.cclk = rif.wdata[CTL_CCLK];
         next_s.ldis = rif.wdata[CTL_DIS];
         next_s.aspm = rif.wdata[CTL_ASPM_LO +: 2];
         next_s.retrain = rif.wdata[CTL_RETRAIN];
         if (!s.rcb_locked) begin
            next_s.rcb = rif.wdata[CTL_RCB];
            next_s.rcb_locked = 1'b1;
         end
      end
      // leaving Configuration/Recovery ends the pending request
      if (s.cfg_rec_q && !ltssm_cfg_rec) begin
         next_s.train_pend = 1'b0;
      end
      // a retrain write in the same cycle wins over the clear
      if (retrain_wr) begin
         next_s.train_pend = 1'b1;
      end
      next_s.training = next_s.train_pend || ltssm_cfg_rec;
      next_s.seen_cap = s.seen_cap || wr_cap;
      next_s.seen_ctl = s.seen_ctl || wr_ctl;
      // burst bookkeeping seen from the transmitter side
      if (!tx_os_valid && (l0s_exit_start || l1_exit_start)) begin
         next_s.ah_cnt = '0;
         next_s.ah_l1 = !l0s_exit_start;
         next_s.ah_ext = s.xsync;
      end else if (os_take && tx_os_kind != PLC_OS_SKP) begin
         next_s.ah_cnt = s.ah_cnt + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= TOP_RST;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // ==========================================
   // register reads
   always_comb begin
      rif.rdata = '0;
      rif.rd_err = 1'b0;
      if (plc_hit(rif.rd_addr, PLC_LCAP_OFF)) begin
         rif.rdata[CAP_LAT_LO +: 3] = s.lat;
         rif.rdata[CAP_ASPM_LO +: 2] = s.aspm_sup;
         rif.rdata[CAP_WID_LO +: 6] = MAX_WIDTH;
         rif.rdata[CAP_SPD_LO +: 4] = MAX_SPEED;
      end else if (plc_hit(rif.rd_addr, PLC_LCTL_OFF)) begin
         // retrain and reserved bits stay at the zero default
         rif.rdata[CTL_ASPM_LO +: 2] = s.aspm;
         rif.rdata[CTL_RCB] = s.rcb;
         rif.rdata[CTL_DIS] = s.ldis;
         rif.rdata[CTL_CCLK] = s.cclk;
         rif.rdata[CTL_XSYNC] = s.xsync;
         rif.rdata[STS_TRAIN] = s.training;
      end else begin
         rif.rd_err = 1'b1;
      end
   end

   // ==========================================
   // outputs
   assign retrain_req = s.retrain;
   assign link_disable = s.ldis;
   assign aspm_ctl = s.aspm;
   assign common_clk = s.cclk;
   assign rcb_128 = s.rcb;
   assign link_training = s.training;

   // ==========================================
   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence s_ctl_wr;
      ce && ctl_lane;
   endsequence

   sequence s_retrain_wr;
      s_ctl_wr ##0 rif.wdata[CTL_RETRAIN];
   endsequence

   sequence s_skp_taken;
      ce && os_take && tx_os_kind == PLC_OS_SKP;
   endsequence

   a_lat_reset: assert property (
      !s.seen_cap |-> s.lat == LAT_RST)
      else $error("exit latency left its reset code before any write");

   a_aspm_sup_reset: assert property (
      !s.seen_cap |-> s.aspm_sup == ASPMS_RST)
      else $error("ASPM support left its reset code before any write");

   a_max_width: assert property (
      plc_hit(rif.rd_addr, PLC_LCAP_OFF) |-> rif.rdata[CAP_WID_LO +: 6] == MAX_WIDTH)
      else $error("maximum link width reads wrong");

   a_max_speed: assert property (
      plc_hit(rif.rd_addr, PLC_LCAP_OFF) |-> rif.rdata[CAP_SPD_LO +: 4] == MAX_SPEED)
      else $error("maximum link speed reads wrong");

   a_ctl_reset: assert property (
      !s.seen_ctl |-> !s.xsync && !common_clk && !link_disable && !rcb_128 &&
                      aspm_ctl == ASPMC_RST && !retrain_req)
      else $error("link control not zero before first write");

   a_fts_count: assert property (
      s_skp_taken |-> s.ah_ext && !s.ah_l1 && s.ah_cnt == CNT_W'(N_EXT_FTS))
      else $error("SKP sent without the full extended FTS burst");

   a_skp_single: assert property (
      s_skp_taken |=> os_seq_done && !tx_os_valid)
      else $error("more than one SKP after the FTS burst");

   a_ts1_count: assert property (
      (os_seq_done && s.ah_l1 && s.ah_ext) |-> s.ah_cnt == CNT_W'(N_EXT_TS1))
      else $error("extended TS1 burst has the wrong length");

   a_os_hold: assert property (
      (tx_os_valid && !tx_os_ready) |=> tx_os_valid && $stable(tx_os_kind))
      else $error("ordered set dropped before it was taken");

   a_cclk_write: assert property (
      s_ctl_wr |=> common_clk == $past(rif.wdata[CTL_CCLK]))
      else $error("common clock bit did not take the write");

   a_retrain_pulse: assert property (
      s_retrain_wr |=> retrain_req)
      else $error("retrain write gave no request to the LTSSM");

   a_retrain_zero: assert property (
      plc_hit(rif.rd_addr, PLC_LCTL_OFF) |-> !rif.rdata[CTL_RETRAIN])
      else $error("retrain bit read back as one");

   a_disable_write: assert property (
      s_ctl_wr |=> link_disable == $past(rif.wdata[CTL_DIS]))
      else $error("link disable output did not follow the write");

   a_disable_read: assert property (
      (s_ctl_wr ##1 plc_hit(rif.rd_addr, PLC_LCTL_OFF)) |->
         rif.rdata[CTL_DIS] == $past(rif.wdata[CTL_DIS]))
      else $error("link disable read differs from last write");

   a_rcb_once: assert property (
      s.rcb_locked |=> $stable(rcb_128))
      else $error("RCB changed after its first write");

   a_aspm_write: assert property (
      s_ctl_wr |=> aspm_ctl == $past(rif.wdata[CTL_ASPM_LO +: 2]))
      else $error("ASPM control did not take the write");

   a_train_set: assert property (
      s_retrain_wr |=> link_training && s.train_pend)
      else $error("training flag not set by retrain write");

   a_train_clear: assert property (
      (ce && s.cfg_rec_q && !ltssm_cfg_rec && !retrain_wr) |=> !link_training)
      else $error("training flag stuck after LTSSM exit");

   a_cap_once: assert property (
      s.cap_locked |=> $stable(s.lat) && $stable(s.aspm_sup))
      else $error("write-once capability field changed twice");

   a_ctl_reserved: assert property (
      plc_hit(rif.rd_addr, PLC_LCTL_OFF) |-> (rif.rdata & CTL_RSV_MASK) == '0)
      else $error("reserved link control bits read nonzero");

   a_xsync_write: assert property (
      s_ctl_wr |=> s.xsync == $past(rif.wdata[CTL_XSYNC]))
      else $error("extended synch bit did not take the write");

   a_rcb_read: assert property (
      plc_hit(rif.rd_addr, PLC_LCTL_OFF) |-> rif.rdata[CTL_RCB] == rcb_128)
      else $error("RCB read differs from the stored value");

   a_train_follow: assert property (
      (ce && ltssm_cfg_rec) |=> link_training)
      else $error("training flag low while LTSSM trains");
endmodule
`default_nettype wire

/* inc/plc_pkg.sv */
// Purpose: shared constants and types of the link capability/control bank
// Assumes: 32-bit AXI4-Lite register access, byte addresses
// Notes: each register is one aligned word
package plc_pkg;
   // ==========================================
   // register map
   localparam int unsigned PLC_AW = 8;
   localparam logic [PLC_AW-1:0] PLC_LCAP_OFF = 8'hDC;
   localparam logic [PLC_AW-1:0] PLC_LCTL_OFF = 8'hE0;
   localparam logic [1:0] PLC_RESP_OK = 2'h0;
   localparam logic [1:0] PLC_RESP_ERR = 2'h2;
   // ==========================================
   // field positions
   localparam int unsigned CAP_SPD_LO = 0;
   localparam int unsigned CAP_WID_LO = 4;
   localparam int unsigned CAP_ASPM_LO = 10;
   localparam int unsigned CAP_LAT_LO = 12;
   localparam int unsigned CTL_ASPM_LO = 0;
   localparam int unsigned CTL_RCB = 3;
   localparam int unsigned CTL_DIS = 4;
   localparam int unsigned CTL_RETRAIN = 5;
   localparam int unsigned CTL_CCLK = 6;
   localparam int unsigned CTL_XSYNC = 7;
   localparam int unsigned STS_TRAIN = 27;
   localparam int unsigned LANE_CTL = 0;
   localparam int unsigned LANE_WO = 1;
   localparam logic [31:0] CTL_RSV_MASK = 32'h0000FF04;
   // ==========================================
   // reset values
   localparam logic [2:0] LAT_RST = 3'h4;
   localparam logic [1:0] ASPMS_RST = 2'h3;
   localparam logic [1:0] ASPMC_RST = 2'h0;
   localparam logic [5:0] WIDTH_DEF = 6'h01;
   localparam logic [3:0] SPEED_DEF = 4'h1;
   // ==========================================
   // ordered-set burst lengths
   localparam int unsigned CNT_W = 13;
   localparam int unsigned EXT_FTS = 4096;
   localparam int unsigned EXT_TS1 = 1024;
   localparam int unsigned NORM_FTS = 32;
   localparam int unsigned NORM_TS1 = 16;
   typedef enum logic [1:0] {PLC_OS_FTS, PLC_OS_SKP, PLC_OS_TS1} plc_os_e;
   function automatic logic plc_hit(input logic [PLC_AW-1:0] a, input logic [PLC_AW-1:0] off);
      return a[PLC_AW-1:2] == off[PLC_AW-1:2];
   endfunction
endpackage

/* inc/plc_reg_if.sv */
// Purpose: register access path between bus front end and register bank
// Assumes: one clock, wr_en is a one-cycle request
// Notes: read data is combinational on rd_addr
`timescale 1ns/1ps
`default_nettype none
interface plc_reg_if;
   logic wr_en;
   logic [plc_pkg::PLC_AW-1:0] wr_addr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic wr_err;
   logic [plc_pkg::PLC_AW-1:0] rd_addr;
   logic [31:0] rdata;
   logic rd_err;
   modport bus (output wr_en, wr_addr, wdata, wstrb, rd_addr, input wr_err, rdata, rd_err);
   modport regs (input wr_en, wr_addr, wdata, wstrb, rd_addr, output wr_err, rdata, rd_err);
endinterface
`default_nettype wire

/* verilog/plc_axil.sv */
// Purpose: AXI4-Lite slave front end of the register bank
// Assumes: one write and one read outstanding at most
// Notes: ready lines drop once an item is held, so no skid buffer needed
`timescale 1ns/1ps
`default_nettype none
module plc_axil (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [plc_pkg::PLC_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [plc_pkg::PLC_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   plc_reg_if.bus rif
);
   import plc_pkg::*;
   typedef struct packed {
      logic aw_rdy, w_rdy, ar_rdy, aw_got, w_got, bvalid, rvalid;
      logic [PLC_AW-1:0] waddr;
      logic [31:0] wdata, rdata;
      logic [3:0] wstrb;
      logic [1:0] bresp, rresp;
   } plc_axil_s;
   localparam plc_axil_s AXIL_RST = '{aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1, default: '0};
   plc_axil_s s, next_s;

   // ==========================================
   // channel handshakes
   always_comb begin
      next_s = s;
      if (s_axi_awvalid && s.aw_rdy) begin
         next_s.aw_rdy = 1'b0;
         next_s.aw_got = 1'b1;
         next_s.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.w_rdy) begin
         next_s.w_rdy = 1'b0;
         next_s.w_got = 1'b1;
         next_s.wdata = s_axi_wdata;
         next_s.wstrb = s_axi_wstrb;
      end
      if (s.aw_got && s.w_got) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = rif.wr_err ? PLC_RESP_ERR : PLC_RESP_OK;
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
         next_s.aw_rdy = 1'b1;
         next_s.w_rdy = 1'b1;
      end
      if (s_axi_arvalid && s.ar_rdy) begin
         next_s.ar_rdy = 1'b0;
         next_s.rvalid = 1'b1;
         next_s.rdata = rif.rdata;
         next_s.rresp = rif.rd_err ? PLC_RESP_ERR : PLC_RESP_OK;
      end
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
         next_s.ar_rdy = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= AXIL_RST;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign rif.wr_en = s.aw_got && s.w_got;
   assign rif.wr_addr = s.waddr;
   assign rif.wdata = s.wdata;
   assign rif.wstrb = s.wstrb;
   assign rif.rd_addr = s_axi_araddr;
   assign s_axi_awready = s.aw_rdy;
   assign s_axi_wready = s.w_rdy;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.ar_rdy;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
endmodule
`default_nettype wire

/* verilog/plc_os_seq.sv */
// Purpose: ordered-set burst sequencer for L0s and L1 exit
// Assumes: transmitter takes one ordered set per os_ready cycle
// Notes: start requests are ignored while a burst runs
`timescale 1ns/1ps
`default_nettype none
module plc_os_seq #(
   parameter int unsigned N_EXT_FTS = plc_pkg::EXT_FTS,
   parameter int unsigned N_EXT_TS1 = plc_pkg::EXT_TS1,
   parameter int unsigned N_NORM_FTS = plc_pkg::NORM_FTS,
   parameter int unsigned N_NORM_TS1 = plc_pkg::NORM_TS1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic ext_synch,
   input wire logic l0s_exit,
   input wire logic l1_exit,
   input wire logic os_ready,
   output logic os_valid,
   output plc_pkg::plc_os_e os_kind,
   output logic os_done
);
   import plc_pkg::*;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_FTS, SEQ_SKP, SEQ_TS1} plc_seq_e;
   typedef struct packed {
      plc_seq_e st;
      logic ext, valid, done;
      plc_os_e kind;
      logic [CNT_W-1:0] cnt;
   } plc_seq_s;
   localparam plc_seq_s SEQ_RST = '{st: SEQ_IDLE, kind: PLC_OS_FTS, default: '0};
   plc_seq_s s, next_s;

   function automatic logic [CNT_W-1:0] plc_load(input logic ext, input int unsigned e,
                                                  input int unsigned n);
      return ext ? CNT_W'(e - 1) : CNT_W'(n - 1);
   endfunction

   // ==========================================
   // burst control
   always_comb begin
      logic fin;
      fin = 1'b0;
      next_s = s;
      next_s.done = 1'b0;
      case (s.st)
         SEQ_IDLE: begin
            // L0s exit wins if both starts arrive together
            if (l0s_exit) begin
               next_s.st = SEQ_FTS;
               next_s.kind = PLC_OS_FTS;
               next_s.cnt = plc_load(ext_synch, N_EXT_FTS, N_NORM_FTS);
               next_s.ext = ext_synch;
               next_s.valid = 1'b1;
            end else if (l1_exit) begin
               next_s.st = SEQ_TS1;
               next_s.kind = PLC_OS_TS1;
               next_s.cnt = plc_load(ext_synch, N_EXT_TS1, N_NORM_TS1);
               next_s.ext = ext_synch;
               next_s.valid = 1'b1;
            end
         end
         SEQ_FTS: if (os_ready) begin
            if (s.cnt != '0) begin
               next_s.cnt = s.cnt - 1'b1;
            end else if (s.ext) begin
               next_s.st = SEQ_SKP;
               next_s.kind = PLC_OS_SKP;
            end else begin
               fin = 1'b1;
            end
         end
         SEQ_SKP: fin = os_ready;
         SEQ_TS1: if (os_ready) begin
            if (s.cnt != '0) begin
               next_s.cnt = s.cnt - 1'b1;
            end else begin
               fin = 1'b1;
            end
         end
         default: next_s = SEQ_RST;
      endcase
      if (fin) begin
         next_s.st = SEQ_IDLE;
         next_s.valid = 1'b0;
         next_s.done = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= SEQ_RST;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign os_valid = s.valid;
   assign os_kind = s.kind;
   assign os_done = s.done;
endmodule
`default_nettype wire

/* dv/plc_tx_model.sv */
// Purpose: far-side transmitter and LTSSM stand-in
// Assumes: same clock as the bank
// Notes: ready toggles so every burst meets stalls
`timescale 1ns/1ps
`default_nettype none
module plc_tx_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic retrain_req,
   input wire logic tx_os_valid,
   input wire plc_pkg::plc_os_e tx_os_kind,
   output logic tx_os_ready,
   output logic ltssm_cfg_rec,
   output int n_fts,
   output int n_skp,
   output int n_ts1,
   output int n_rt
);
   import plc_pkg::*;
   int cnt;
   // ==========================================
   // recovery entered some cycles after a retrain request, left later
   assign ltssm_cfg_rec = (cnt > 0) && (cnt <= 8);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         n_rt <= 0;
         n_fts <= 0;
         n_skp <= 0;
         n_ts1 <= 0;
         tx_os_ready <= 1'b0;
      end else begin
         tx_os_ready <= !tx_os_ready;
         if (retrain_req) begin
            cnt <= 16;
            n_rt <= n_rt + 1;
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
         end
         if (tx_os_valid && tx_os_ready) begin
            if (tx_os_kind == PLC_OS_FTS) n_fts <= n_fts + 1;
            if (tx_os_kind == PLC_OS_SKP) n_skp <= n_skp + 1;
            if (tx_os_kind == PLC_OS_TS1) n_ts1 <= n_ts1 + 1;
         end
      end
   end
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Purpose: register and ordered-set checks of the link bank
// Assumes: short burst counts 8/4/3/2
// Notes: bready and rready raised per transfer, dropped once answered
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import plc_pkg::*;
   logic mclk, rst_n, awv, wv, arv, l0s, l1, awr, wrd, bv, arr, rv;
   logic rtq, dis, cclk, rcb, trn, osv, osd, osr, rec, bry, rry;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdd, got;
   logic [3:0] ws;
   logic [1:0] br, rr, aspm, resp;
   plc_os_e osk;
   int num_errors, total_checks, nf, ns, nt, nr;
   plc_link_top #(.N_EXT_FTS(8), .N_EXT_TS1(4), .N_NORM_FTS(3), .N_NORM_TS1(2)) i_plc_link_top (
      .mclk(mclk), .rst_n(rst_n), .ce(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .ltssm_cfg_rec(rec),
      .retrain_req(rtq), .link_disable(dis), .aspm_ctl(aspm), .common_clk(cclk),
      .rcb_128(rcb), .link_training(trn), .l0s_exit_start(l0s), .l1_exit_start(l1),
      .tx_os_ready(osr), .tx_os_valid(osv), .tx_os_kind(osk), .os_seq_done(osd));
   plc_tx_model i_plc_tx_model (.mclk(mclk), .rst_n(rst_n), .retrain_req(rtq),
      .tx_os_valid(osv), .tx_os_kind(osk), .tx_os_ready(osr), .ltssm_cfg_rec(rec),
      .n_fts(nf), .n_skp(ns), .n_ts1(nt), .n_rt(nr));
   // ==========================================
   // tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // handshakes judged on the falling edge, since inputs only move on the rising one
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ta, tw, tb;
      tb = 1'b0;
      @(posedge mclk);
      awa <= a;
      wd <= d;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      while (!tb) begin
         @(negedge mclk);
         ta = awv && awr;
         tw = wv && wrd;
         tb = bv;
         resp = br;
         @(posedge mclk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (tb) bry <= 1'b0;
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic t, dn;
      dn = 1'b0;
      @(posedge mclk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      while (!dn) begin
         @(negedge mclk);
         t = arv && arr;
         dn = rv;
         got = rdd;
         resp = rr;
         @(posedge mclk);
         if (t) arv <= 1'b0;
         if (dn) rry <= 1'b0;
      end
      chk(got, e);
      chk({30'h0, resp}, {30'h0, er});
   endtask
   task automatic burst(input logic l0, input int ef, input int es, input int et);
      int f0, s0, t0, k;
      f0 = nf;
      s0 = ns;
      t0 = nt;
      k = 0;
      @(posedge mclk);
      l0s <= l0;
      l1 <= !l0;
      @(posedge mclk);
      l0s <= 1'b0;
      l1 <= 1'b0;
      while (osd !== 1'b1 && k < 500) begin
         @(negedge mclk);
         k++;
      end
      chk({31'h0, osd}, 32'h1);
      chk(32'(nf - f0), 32'(ef));
      chk(32'(ns - s0), 32'(es));
      chk(32'(nt - t0), 32'(et));
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ==========================================
   // clock, watchdog, tests
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      #(25ns * 20000);
      num_errors++;
      close_out;
   end
   initial begin
      {rst_n, awv, wv, arv, l0s, l1, awa, ara, wd, ws, bry, rry} = '0;
      num_errors = 0;
      total_checks = 0;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      rd(PLC_LCAP_OFF, 32'h4C11, PLC_RESP_OK);
      rd(PLC_LCTL_OFF, 32'h0, PLC_RESP_OK);
      wr(PLC_LCTL_OFF, 32'hFFFFFFFF, 4'hF);
      @(negedge mclk);
      chk({30'h0, resp}, {30'h0, PLC_RESP_OK});
      chk({26'h0, dis, cclk, rcb, aspm, trn}, 32'h3F);
      chk(32'(nr), 32'h1);
      rd(PLC_LCTL_OFF, 32'h080000DB, PLC_RESP_OK);
      repeat (30) @(posedge mclk);
      rd(PLC_LCTL_OFF, 32'hDB, PLC_RESP_OK);
      wr(PLC_LCTL_OFF, 32'h0, 4'h1);
      rd(PLC_LCTL_OFF, 32'h08, PLC_RESP_OK);
      wr(PLC_LCAP_OFF, 32'h1000, 4'h2);
      rd(PLC_LCAP_OFF, 32'h1011, PLC_RESP_OK);
      wr(PLC_LCAP_OFF, 32'h7C00, 4'h2);
      rd(PLC_LCAP_OFF, 32'h1011, PLC_RESP_OK);
      for (int i = 0; i < 4; i++) begin
         wr(PLC_LCTL_OFF, 32'(i), 4'h1);
         chk({30'h0, aspm}, 32'(i));
      end
      wr(8'h40, 32'hFF, 4'hF);
      chk({30'h0, resp}, {30'h0, PLC_RESP_ERR});
      rd(8'h40, 32'h0, PLC_RESP_ERR);
      wr(PLC_LCTL_OFF, 32'h80, 4'h1);
      burst(1'b1, 8, 1, 0);
      burst(1'b0, 0, 0, 4);
      wr(PLC_LCTL_OFF, 32'h0, 4'h1);
      burst(1'b1, 3, 0, 0);
      burst(1'b0, 0, 0, 2);
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd(PLC_LCTL_OFF, 32'h0, PLC_RESP_OK);
      rd(PLC_LCAP_OFF, 32'h4C11, PLC_RESP_OK);
      close_out;
   end
endmodule
`default_nettype wire
